/* File: design/tmon_top.sv */
/*
  Telemetry threshold monitor: input power product and over-power
  monitor, stage temperature, sense-pin voltage and output voltage
  monitors for two loops, sense-pin self-check, AXI4-Lite registers.
  Assumes ADC codes arrive on aclk; sense-pin comparators are async.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
// Summary of operation
// (RULE_01) power readback is input voltage code times input current code, 16 bits; the code returns the product shifted right by PWR_SHIFT (4).
// (RULE_02) power at or above trip level past the delay sets over-power flag, fault.
// (RULE_03) power at or below release level past the delay releases; clearing per config.
// (RULE_04) power levels are 11-bit fields times 0.3 W, trip and release separate.
// (RULE_05) release field resets to 0x1F4, trip field resets to 0x258.
// (RULE_06) zero trip field disables the over-power monitor.
// (RULE_07) each loop's 9-bit stage temperature code is readable.
// (RULE_08) temperature at or above warning level past delay sets warning while present.
// (RULE_09) temperature at or above shutdown level past delay sets shutdown flag.
// (RULE_10) temperature levels are 9-bit fields in ADC steps, 8-step hysteresis; the code applies the hysteresis to the warning release only.
// (RULE_11) warning field resets to 0x12C, shutdown field to 0x152.
// (RULE_12) zero warning or shutdown field disables that temperature monitor.
// (RULE_13) sense pin low past the 75 us filter sets undervoltage flag.
// (RULE_14) sense pin high past the 75 us filter sets overvoltage flag.
// (RULE_15) a self-check forces both sense comparators and records the result.
// (RULE_16) each loop's 12-bit output voltage code is readable.
// (RULE_17) output at or below undervoltage limit past delay sets flag, fault.
// (RULE_18) output at or above overvoltage limit past delay sets flag, fault.
// (RULE_19) output limits are 9-bit fields times eight ADC steps.
// (RULE_20) undervoltage limit resets to 0x058, overvoltage limit to 0x06D.
// (RULE_21) zero output limit field disables that output monitor.
// (RULE_22) any monitor timer restarts when its condition drops early.
// (RULE_23) flags are readable; each new flag gives a one-cycle event.
`timescale 1ns/1ps
module tmon_top
  import tmon_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  input  wire tmon_adc_t         adc,
  input  wire logic [1:0]        cmp_uv,
  input  wire logic [1:0]        cmp_ov,
  output logic                   st_force_uv,
  output logic                   st_force_ov,
  output logic [NFLAG-1:0]       fault_event,
  output logic                   fault_o,
  output logic                   fault_oe,
  output logic                   safe_state
);

  tmon_state_t      s_r;
  tmon_state_t      s_nxt;
  logic [19:0]      prod;
  logic [NMON-1:0]  cond;
  logic [NMON-1:0]  qual;
  logic             st_start;
  logic             st_busy;

  // ==========================================
  // helpers
  function automatic logic [31:0] be_mask(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  function automatic logic [31:0] pwr_uw(input logic [15:0] p);
    return 32'(p) * PWR_LSB_UW;
  endfunction

  function automatic logic [31:0] pth_uw(input logic [10:0] f);
    return 32'(f) * PTH_LSB_UW;
  endfunction

  function automatic logic [11:0] vth(input logic [8:0] f);
    return 12'(f) << VTH_SHIFT;
  endfunction

  // sense-pin checks use the filter time, all others the detection delay
  function automatic logic [10:0] mon_lim(input int i);
    return (i >= F_PUV && i < F_VUV) ? FILT_CYC : DET_CYC;
  endfunction

  // bit 32 marks a mapped address
  function automatic logic [32:0] reg_rd(input logic [5:0] a);
    logic [32:0] v;
    v = {1'b1, 32'h0000_0000};
    case (a)
      OFF_PWR:            v[15:0] = s_r.pwr; // RULE_01
      OFF_PTH:            v[31:0] = {5'h00, s_r.rel, 5'h00, s_r.trip};
      OFF_TTH0, OFF_TTH1: v[31:0] = {7'h00, s_r.sd_th[a[2]], 7'h00, s_r.warn_th[a[2]]};
      OFF_VTH0, OFF_VTH1: v[31:0] = {7'h00, s_r.ov_th[a[2]], 7'h00, s_r.uv_th[a[2]]};
      OFF_TRD:            v[31:0] = {7'h00, adc.temp[1], 7'h00, adc.temp[0]}; // RULE_07
      OFF_VRD:            v[31:0] = {4'h0, adc.vout[1], 4'h0, adc.vout[0]}; // RULE_16
      OFF_STAT:           v[NFLAG-1:0] = s_r.flag; // RULE_23
      OFF_CFG:            v[2:0] = s_r.cfg;
      OFF_STST:           v[2:0] = {s_r.ov_ok, s_r.uv_ok, st_busy};
      default:            v = 33'h0_0000_0000;
    endcase
    return v;
  endfunction

  assign prod    = 20'(adc.vin) * 20'(adc.iin); // RULE_01
  assign st_busy = s_r.st != ST_IDLE;

  // ==========================================
  // next state
  always_comb begin
    logic [32:0]      rv;
    logic [31:0]      wd;
    logic [31:0]      m;
    logic [NFLAG-1:0] sw_clr;
    logic [NFLAG-1:0] gone;
    rv       = 33'h0_0000_0000;
    wd       = 32'h0000_0000;
    m        = 32'h0000_0000;
    sw_clr   = '0;
    gone     = '0;
    s_nxt    = s_r;
    st_start = 1'b0;
    cond     = '0;
    qual     = '0;

    // comparator levels change only once the last two stages agree
    s_nxt.sy1 = {cmp_ov, cmp_uv};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sy3 = s_r.sy2;
    for (int k = 0; k < 4; k++) begin
      if (s_r.sy2[k] == s_r.sy3[k]) begin
        s_nxt.lvl[k] = s_r.sy3[k];
      end
    end

    // ==========================================
    // monitor conditions
    s_nxt.pwr   = prod[PWR_SHIFT +: 16]; // RULE_01
    cond[F_OP]  = s_r.trip != 11'h000 && pwr_uw(s_r.pwr) >= pth_uw(s_r.trip); // RULE_02 RULE_04 RULE_06
    cond[M_REL] = s_r.trip != 11'h000 && pwr_uw(s_r.pwr) <= pth_uw(s_r.rel); // RULE_03 RULE_04
    for (int l = 0; l < 2; l++) begin
      cond[F_WARN+l] = s_r.warn_th[l] != 9'h000 && adc.temp[l] >= s_r.warn_th[l]; // RULE_08 RULE_10 RULE_12
      cond[F_SD+l]   = s_r.sd_th[l] != 9'h000 && adc.temp[l] >= s_r.sd_th[l]; // RULE_09 RULE_12
      // a self-check drives the comparators, so the pin monitors pause
      cond[F_PUV+l]  = !st_busy && s_r.lvl[l]; // RULE_13
      cond[F_POV+l]  = !st_busy && s_r.lvl[2+l]; // RULE_14
      cond[F_VUV+l]  = s_r.uv_th[l] != 9'h000 && adc.vout[l] <= vth(s_r.uv_th[l]); // RULE_17 RULE_19 RULE_21
      cond[F_VOV+l]  = s_r.ov_th[l] != 9'h000 && adc.vout[l] >= vth(s_r.ov_th[l]); // RULE_18 RULE_19 RULE_21
      gone[F_WARN+l] = s_r.warn_th[l] == 9'h000 ||
                       {1'b0, adc.temp[l]} + {1'b0, TEMP_HYST} < {1'b0, s_r.warn_th[l]}; // RULE_10
    end

    // ==========================================
    // qualification timers
    for (int i = 0; i < NMON; i++) begin
      if (!cond[i]) begin
        s_nxt.cnt[i] = 11'h000; // RULE_22
      end else if (s_r.cnt[i] == mon_lim(i)) begin
        qual[i] = 1'b1;
      end else begin
        s_nxt.cnt[i] = s_r.cnt[i] + 11'h001;
      end
    end

    if (s_r.cfg[CFG_AUTOCLR]) begin
      gone       = gone | (~cond[NFLAG-1:0] & FAULT_MSK); // RULE_09
      gone[F_OP] = qual[M_REL]; // RULE_03
    end

    // ==========================================
    // AXI4-Lite slave
    if (awvalid && !s_r.aw_v) begin
      s_nxt.aw_v = 1'b1;
      s_nxt.aw_a = awaddr;
    end
    if (wvalid && !s_r.w_v) begin
      s_nxt.w_v = 1'b1;
      s_nxt.w_d = wdata;
      s_nxt.w_s = wstrb;
    end
    if (s_r.b_v && bready) begin
      s_nxt.b_v = 1'b0;
    end
    // a new write waits until the previous response is taken
    if (s_r.aw_v && s_r.w_v && !s_r.b_v) begin
      rv         = reg_rd(s_r.aw_a);
      m          = be_mask(s_r.w_s);
      wd         = (rv[31:0] & ~m) | (s_r.w_d & m);
      s_nxt.aw_v = 1'b0;
      s_nxt.w_v  = 1'b0;
      s_nxt.b_v  = 1'b1;
      s_nxt.b_r  = rv[32] ? RESP_OKAY : RESP_SLVERR;
      case (s_r.aw_a)
        OFF_PTH: begin
          s_nxt.trip = wd[10:0];
          s_nxt.rel  = wd[HI_POS +: 11];
        end
        OFF_TTH0, OFF_TTH1: begin
          s_nxt.warn_th[s_r.aw_a[2]] = wd[8:0];
          s_nxt.sd_th[s_r.aw_a[2]]   = wd[HI_POS +: 9];
        end
        OFF_VTH0, OFF_VTH1: begin
          s_nxt.uv_th[s_r.aw_a[2]] = wd[8:0];
          s_nxt.ov_th[s_r.aw_a[2]] = wd[HI_POS +: 9];
        end
        OFF_STAT: sw_clr = s_r.w_d[NFLAG-1:0] & m[NFLAG-1:0];
        OFF_CFG:  s_nxt.cfg = wd[2:0];
        OFF_STST: st_start = wd[0] && !st_busy;
        default:  ;
      endcase
    end
    if (s_r.r_v && rready) begin
      s_nxt.r_v = 1'b0;
    end
    if (arvalid && !s_r.r_v) begin
      rv        = reg_rd(araddr);
      s_nxt.r_v = 1'b1;
      s_nxt.r_d = rv[31:0];
      s_nxt.r_r = rv[32] ? RESP_OKAY : RESP_SLVERR;
    end

    // ==========================================
    // flags, events, fault pin; a new detection beats a clear
    s_nxt.flag = (s_r.flag & ~(gone | sw_clr)) | qual[NFLAG-1:0]; // RULE_02 RULE_08 RULE_17 RULE_18
    s_nxt.evt  = qual[NFLAG-1:0] & ~s_r.flag; // RULE_23
    s_nxt.foe  = s_r.cfg[CFG_PIN_EN] && |(s_r.flag & FAULT_MSK); // RULE_02 RULE_17
    s_nxt.safe = s_r.cfg[CFG_SAFE_EN] && |(s_r.flag & SAFE_MSK); // RULE_09

    // ==========================================
    // sense-pin self-check
    s_nxt.st_cnt = s_r.st_cnt + 5'h01;
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.st_cnt = 5'h00;
        if (st_start) begin
          s_nxt.st    = ST_UV; // RULE_15
          s_nxt.uv_ok = 1'b0;
          s_nxt.ov_ok = 1'b0;
        end
      end
      ST_UV: begin
        if (&s_r.lvl[1:0] || s_r.st_cnt == ST_WAIT) begin
          s_nxt.st     = ST_OV;
          s_nxt.uv_ok  = &s_r.lvl[1:0]; // RULE_15
          s_nxt.st_cnt = 5'h00;
        end
      end
      ST_OV: begin
        if (&s_r.lvl[3:2] || s_r.st_cnt == ST_WAIT) begin
          s_nxt.st    = ST_IDLE;
          s_nxt.ov_ok = &s_r.lvl[3:2]; // RULE_15
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  // ==========================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      s_r.trip    <= PWR_TRIP_RST; // RULE_05
      s_r.rel     <= PWR_REL_RST;
      s_r.warn_th <= {2{TEMP_WARN_RST}}; // RULE_11
      s_r.sd_th   <= {2{TEMP_SD_RST}};
      s_r.uv_th   <= {2{VOUT_UV_RST}}; // RULE_20
      s_r.ov_th   <= {2{VOUT_OV_RST}};
      s_r.cfg     <= CFG_RST;
      s_r.st      <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready     = !s_r.aw_v;
  assign wready      = !s_r.w_v;
  assign bvalid      = s_r.b_v;
  assign bresp       = s_r.b_r;
  assign arready     = !s_r.r_v;
  assign rvalid      = s_r.r_v;
  assign rdata       = s_r.r_d;
  assign rresp       = s_r.r_r;
  assign fault_event = s_r.evt;
  assign fault_o     = 1'b0;
  assign fault_oe    = s_r.foe;
  assign safe_state  = s_r.safe;
  assign st_force_uv = s_r.st == ST_UV;
  assign st_force_ov = s_r.st == ST_OV;

  // ==========================================
  // assertions
  localparam int ST_SPAN = 2 * (int'(ST_WAIT) + 2);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_pwr_prod;
    ##1 s_r.pwr == 16'((20'($past(adc.vin)) * 20'($past(adc.iin))) >> PWR_SHIFT);
  endproperty
  a_pwr_prod: assert property (p_pwr_prod) else $error("power readback wrong"); // RULE_01

  property p_op_set;
    qual[F_OP] && !s_r.flag[F_OP] |=> s_r.flag[F_OP] && fault_event[F_OP] ##1 fault_oe || !s_r.cfg[CFG_PIN_EN];
  endproperty
  a_op_set: assert property (p_op_set) else $error("over-power not flagged"); // RULE_02

  property p_op_rel;
    s_r.cfg[CFG_AUTOCLR] && qual[M_REL] && !qual[F_OP] |=> !s_r.flag[F_OP];
  endproperty
  a_op_rel: assert property (p_op_rel) else $error("over-power not released"); // RULE_03

  property p_rst_vals;
    !$past(aresetn) |-> s_r.trip == PWR_TRIP_RST && s_r.rel == PWR_REL_RST;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("power field reset wrong"); // RULE_05

  property p_op_off;
    s_r.trip == 11'h000 |=> !$rose(s_r.flag[F_OP]);
  endproperty
  a_op_off: assert property (p_op_off) else $error("disabled power monitor fired"); // RULE_06

  property p_warn_time;
    $rose(s_r.flag[F_WARN]) |-> $past(s_r.cnt[F_WARN]) == DET_CYC && $past(cond[F_WARN]);
  endproperty
  a_warn_time: assert property (p_warn_time) else $error("warning set early"); // RULE_08

  property p_puv_time;
    $rose(s_r.flag[F_PUV]) |-> $past(s_r.cnt[F_PUV]) == FILT_CYC;
  endproperty
  a_puv_time: assert property (p_puv_time) else $error("pin undervoltage filter short"); // RULE_13

  sequence s_st_kick;
    st_start;
  endsequence
  sequence s_st_run;
    st_busy [*2] ##[1:ST_SPAN] !st_busy;
  endsequence
  property p_selftest;
    s_st_kick |=> s_st_run;
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-check did not run"); // RULE_15

  property p_vov_off;
    s_r.ov_th[0] == 9'h000 |-> !cond[F_VOV] ##1 !$rose(s_r.flag[F_VOV]) || s_r.ov_th[0] != 9'h000;
  endproperty
  a_vov_off: assert property (p_vov_off) else $error("disabled overvoltage fired"); // RULE_21

  property p_restart;
    !cond[F_VUV] |=> s_r.cnt[F_VUV] == 11'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted"); // RULE_22

  property p_evt_pulse;
    fault_event[F_SD] |=> !fault_event[F_SD] && s_r.flag[F_SD];
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than one cycle"); // RULE_23

endmodule

/* File: inc/tmon_pkg.sv */
/*
  Telemetry threshold monitor package: register map, field layout,
  reset values, timing counts, carrier and state types.
  Assumes one 20 MHz aclk and an AXI4-Lite slave port with 32-bit data.
*/
package tmon_pkg;
  // ==========================================
  // register map and field layout
  localparam int          ADDR_W      = 6;
  localparam logic [5:0]  OFF_PWR     = 6'h00;
  localparam logic [5:0]  OFF_PTH     = 6'h04;
  localparam logic [5:0]  OFF_TTH0    = 6'h08;
  localparam logic [5:0]  OFF_TTH1    = 6'h0C;
  localparam logic [5:0]  OFF_VTH0    = 6'h10;
  localparam logic [5:0]  OFF_VTH1    = 6'h14;
  localparam logic [5:0]  OFF_TRD     = 6'h18;
  localparam logic [5:0]  OFF_VRD     = 6'h1C;
  localparam logic [5:0]  OFF_STAT    = 6'h20;
  localparam logic [5:0]  OFF_CFG     = 6'h24;
  localparam logic [5:0]  OFF_STST    = 6'h28;
  localparam int          HI_POS      = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================
  // reset values
  localparam logic [10:0] PWR_TRIP_RST  = 11'h258;
  localparam logic [10:0] PWR_REL_RST   = 11'h1F4;
  localparam logic [8:0]  TEMP_WARN_RST = 9'h12C;
  localparam logic [8:0]  TEMP_SD_RST   = 9'h152;
  localparam logic [8:0]  VOUT_UV_RST   = 9'h058;
  localparam logic [8:0]  VOUT_OV_RST   = 9'h06D;
  localparam int          CFG_AUTOCLR   = 0;
  localparam int          CFG_PIN_EN    = 1;
  localparam int          CFG_SAFE_EN   = 2;
  localparam logic [2:0]  CFG_RST       = 3'h6;

  // ==========================================
  // scaling and timing
  localparam logic [31:0] PWR_LSB_UW = 32'h0000_4A24;
  localparam logic [31:0] PTH_LSB_UW = 32'h0004_93E0;
  localparam int          PWR_SHIFT  = 4;
  localparam int          VTH_SHIFT  = 3;
  localparam logic [8:0]  TEMP_HYST  = 9'h008;
  localparam int          CLK_NS     = 50;
  localparam int          DET_NS     = 65000;
  localparam int          FILT_NS    = 75000;
  localparam logic [10:0] DET_CYC    = 11'((DET_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] FILT_CYC   = 11'((FILT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0]  ST_WAIT    = 5'h14;

  // ==========================================
  // flag positions; monitor index equals flag index, plus the release timer
  localparam int           F_OP      = 0;
  localparam int           F_WARN    = 1;
  localparam int           F_SD      = 3;
  localparam int           F_PUV     = 5;
  localparam int           F_POV     = 7;
  localparam int           F_VUV     = 9;
  localparam int           F_VOV     = 11;
  localparam int           NFLAG     = 13;
  localparam int           M_REL     = 13;
  localparam int           NMON      = 14;
  localparam logic [12:0]  FAULT_MSK = 13'h1FF9;
  localparam logic [12:0]  SAFE_MSK  = 13'h01F8;

  // ==========================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_UV   = 3'b010,
    ST_OV   = 3'b100
  } tmon_st_t;

  typedef struct packed {
    logic [9:0]       vin;
    logic [9:0]       iin;
    logic [1:0][8:0]  temp;
    logic [1:0][11:0] vout;
  } tmon_adc_t;

  typedef struct packed {
    logic                  aw_v;
    logic [5:0]            aw_a;
    logic                  w_v;
    logic [31:0]           w_d;
    logic [3:0]            w_s;
    logic                  b_v;
    logic [1:0]            b_r;
    logic                  r_v;
    logic [1:0]            r_r;
    logic [31:0]           r_d;
    logic [15:0]           pwr;
    logic [10:0]           trip;
    logic [10:0]           rel;
    logic [1:0][8:0]       warn_th;
    logic [1:0][8:0]       sd_th;
    logic [1:0][8:0]       uv_th;
    logic [1:0][8:0]       ov_th;
    logic [2:0]            cfg;
    logic [13:0][10:0]     cnt;
    logic [12:0]           flag;
    logic [12:0]           evt;
    logic                  foe;
    logic                  safe;
    logic [3:0]            sy1;
    logic [3:0]            sy2;
    logic [3:0]            sy3;
    logic [3:0]            lvl;
    tmon_st_t              st;
    logic [4:0]            st_cnt;
    logic                  uv_ok;
    logic                  ov_ok;
  } tmon_state_t;
endpackage

/* File: tb/tb_tmon_top.sv */
/*
  Self-checking bench for the telemetry threshold monitor: AXI4-Lite tasks,
  register defaults, power product and monitors, self-check.
  Assumes tmon_stage_model as the far side; 20 MHz aclk.
*/
`timescale 1ns/1ps
module tb_tmon_top;
  import tmon_pkg::*;
  // ==========================================
  // signals
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic [5:0]        awaddr = 6'h00;
  logic [5:0]        araddr = 6'h00;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        wstrb = 4'hF;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              st_force_uv, st_force_ov, fault_o, fault_oe, safe_state;
  logic [1:0]        bresp, rresp, cmp_uv, cmp_ov;
  logic [31:0]       rdata;
  logic [NFLAG-1:0]  fault_event;
  tmon_adc_t         adc;
  int                error_cnt = 0;
  int                check_count = 0;

  always #25 aclk = ~aclk;

  tmon_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .adc(adc), .cmp_uv(cmp_uv), .cmp_ov(cmp_ov),
    .st_force_uv(st_force_uv), .st_force_ov(st_force_ov), .fault_event(fault_event),
    .fault_o(fault_o), .fault_oe(fault_oe), .safe_state(safe_state));
  tmon_stage_model mdl (.aclk(aclk), .st_force_uv(st_force_uv), .st_force_ov(st_force_ov),
    .adc(adc), .cmp_uv(cmp_uv), .cmp_ov(cmp_ov));

  // ==========================================
  // reporting
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%08h exp=%08h", $time, got, exp);
    end
  endtask

  task automatic hang;
    chk(32'h0, 32'h1);
    wrap_up();
  endtask

  // ==========================================
  // bus tasks: handshakes judged at the falling edge, taken at the next rising one
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    int   n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    // let the valids settle, or the loop below sees them still low and never releases them
    #1;
    for (n = 0; awvalid || wvalid; n++) begin
      if (n == 100) hang();
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      #1;
    end
    for (n = 0; bvalid !== 1'b1; n++) begin
      if (n == 100) hang();
      @(negedge aclk);
    end
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; !(arvalid && arready); n++) begin
      if (n == 100) hang();
      @(negedge aclk);
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    for (n = 0; rvalid !== 1'b1; n++) begin
      if (n == 100) hang();
      @(negedge aclk);
    end
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // lo above hi asks that no pulse comes within hi cycles
  task automatic wait_evt(input int idx, input int lo, input int hi);
    int n;
    for (n = 0; n <= hi && fault_event[idx] !== 1'b1; n++) @(negedge aclk);
    chk({31'h0, n >= lo && (n <= hi || lo > hi)}, 32'h1);
  endtask

  task automatic selftest(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(OFF_STST, 32'h1, RESP_OKAY);
    for (int n = 0; n < 80; n++) begin
      axi_rd(OFF_STST, d, r);
      if (d[0] === 1'b0) break;
    end
    chk(d, exp);
  endtask

  // ==========================================
  // main sequence
  int dl, dh, fl, fh;
  initial begin
    dl = int'(DET_CYC) - 4;
    dh = int'(DET_CYC) + 10;
    fl = int'(FILT_CYC) - 4;
    fh = int'(FILT_CYC) + 10;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFF_PTH, 32'h01F4_0258, RESP_OKAY);
    rd_chk(OFF_TTH0, 32'h0152_012C, RESP_OKAY);
    rd_chk(OFF_TTH1, 32'h0152_012C, RESP_OKAY);
    rd_chk(OFF_VTH1, 32'h006D_0058, RESP_OKAY);
    rd_chk(OFF_TRD, 32'h0060_0050, RESP_OKAY);
    rd_chk(OFF_VRD, 32'h0341_0340, RESP_OKAY);
    rd_chk(6'h30, 32'h0, RESP_SLVERR);
    axi_wr(6'h30, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("test registers done");
    axi_wr(OFF_PTH, 32'h0, RESP_OKAY);
    mdl.code_r.vin <= 10'h200;
    mdl.code_r.iin <= 10'h100;
    repeat (4) @(posedge aclk);
    rd_chk(OFF_PWR, 32'h0000_2000, RESP_OKAY);
    wait_evt(F_OP, dh + 1, dh);
    axi_wr(OFF_PTH, 32'h0000_0001, RESP_OKAY);
    wait_evt(F_OP, dl - 8, dh);
    @(negedge aclk);
    @(negedge aclk);
    chk({31'h0, fault_oe}, 32'h1);
    chk({31'h0, fault_o}, 32'h0);
    rd_chk(OFF_STAT, 32'h1, RESP_OKAY);
    axi_wr(OFF_CFG, 32'h7, RESP_OKAY);
    mdl.code_r.vin <= 10'h000;
    repeat (dh + 10) @(posedge aclk);
    rd_chk(OFF_STAT, 32'h0, RESP_OKAY);
    axi_wr(OFF_CFG, 32'h6, RESP_OKAY);
    $display("test power done");
    mdl.code_r.vout[0] <= 12'h2C0;
    repeat (1000) @(posedge aclk);
    mdl.code_r.vout[0] <= 12'h340;
    repeat (5) @(posedge aclk);
    mdl.code_r.vout[0] <= 12'h2C0;
    wait_evt(F_VUV, dl, dh);
    mdl.code_r.vout[0] <= 12'h340;
    mdl.code_r.vout[1] <= 12'h368;
    wait_evt(F_VOV + 1, dl, dh);
    mdl.code_r.vout[1] <= 12'h341;
    axi_wr(OFF_VTH0, 32'h0000_0058, RESP_OKAY);
    mdl.code_r.vout[0] <= 12'hFFF;
    wait_evt(F_VOV, dh + 1, dh);
    mdl.code_r.vout[0] <= 12'h340;
    axi_wr(OFF_STAT, 32'h1FFF, RESP_OKAY);
    rd_chk(OFF_STAT, 32'h0, RESP_OKAY);
    $display("test output voltage done");
    mdl.code_r.temp[1] <= 9'h12C;
    wait_evt(F_WARN + 1, dl, dh);
    mdl.code_r.temp[1] <= 9'h125;
    repeat (20) @(posedge aclk);
    rd_chk(OFF_STAT, 32'h4, RESP_OKAY);
    mdl.code_r.temp[1] <= 9'h100;
    repeat (20) @(posedge aclk);
    rd_chk(OFF_STAT, 32'h0, RESP_OKAY);
    mdl.code_r.temp[0] <= 9'h152;
    wait_evt(F_SD, dl, dh);
    @(negedge aclk);
    @(negedge aclk);
    chk({31'h0, safe_state}, 32'h1);
    mdl.code_r.temp[0] <= 9'h050;
    axi_wr(OFF_TTH0, 32'h0, RESP_OKAY);
    axi_wr(OFF_STAT, 32'h1FFF, RESP_OKAY);
    mdl.code_r.temp[0] <= 9'h1FF;
    wait_evt(F_SD, dh + 1, dh);
    rd_chk(OFF_STAT, 32'h0, RESP_OKAY);
    mdl.code_r.temp[0] <= 9'h050;
    $display("test temperature done");
    mdl.uv_pin_r <= 2'h1;
    wait_evt(F_PUV, fl, fh);
    mdl.uv_pin_r <= 2'h0;
    mdl.ov_pin_r <= 2'h2;
    wait_evt(F_POV + 1, fl, fh);
    mdl.ov_pin_r <= 2'h0;
    axi_wr(OFF_STAT, 32'h1FFF, RESP_OKAY);
    selftest(32'h6);
    mdl.ov_stuck_r <= 1'b1;
    selftest(32'h2);
    $display("test sense pin done");
    wrap_up();
  end
endmodule

/* File: tb/tmon_stage_model.sv */
/*
  Far-side model: the power stages' sense outputs as seen through the ADCs,
  plus the two sense-pin comparators that the self-check can force.
  Assumes the bench sets codes and pin levels by writing the registers here
  right after a rising edge of aclk.
*/
`timescale 1ns/1ps
module tmon_stage_model
  import tmon_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  st_force_uv,
  input  wire logic  st_force_ov,
  output tmon_adc_t  adc,
  output logic [1:0] cmp_uv,
  output logic [1:0] cmp_ov
);
  // ==========================================
  // codes and pin levels, healthy at time zero
  tmon_adc_t  code_r     = '{vin: 10'h000, iin: 10'h000, temp: {9'h060, 9'h050}, vout: {12'h341, 12'h340}};
  logic [1:0] uv_pin_r   = 2'h0;
  logic [1:0] ov_pin_r   = 2'h0;
  logic       ov_stuck_r = 1'b0;
  logic [1:0] fuv_r      = 2'h0;
  logic [1:0] fov_r      = 2'h0;

  // ==========================================
  // comparators answer a forced test level two cycles late, like a slow analog path
  always @(posedge aclk) begin
    fuv_r <= {fuv_r[0], st_force_uv};
    fov_r <= {fov_r[0], st_force_ov};
  end
  assign adc    = code_r;
  assign cmp_uv = uv_pin_r | {2{fuv_r[1]}};
  // a stuck overvoltage comparator ignores the forced level
  assign cmp_ov = ov_pin_r | {2{fov_r[1] & ~ov_stuck_r}};
endmodule
